// ==== fpx_defs.svh ====
// Constants for the multiply-flags and not-equal unit
`ifndef FPX_DEFS_SVH
`define FPX_DEFS_SVH
// ------------------------------------------
// Operation codes and latencies
// ------------------------------------------
`define FPX_OP_MUL_FLAGS 8'h8F
`define FPX_OP_NEQ       8'h96
`define FPX_MUL_LAT      3
`define FPX_NEQ_LAT      1
// ------------------------------------------
// Flag vector bit positions
// ------------------------------------------
`define FPX_FL_W   7
`define FPX_FL_INX 1
`define FPX_FL_UNF 2
`define FPX_FL_OVF 3
`define FPX_FL_INV 4
`define FPX_FL_IFZ 5
`define FPX_FL_OFZ 6
`define FPX_RM_LO  8
`define FPX_FL_RST 7'h00
`define FPX_RM_RST 2'h0
// ------------------------------------------
// Register offsets and interrupt layout
// ------------------------------------------
`define FPX_ADR_PSW  8'h00
`define FPX_ADR_ISTA 8'h04
`define FPX_ADR_IEN  8'h08
`define FPX_ADR_ICLR 8'h0C
`define FPX_IRQ_W    2
`define FPX_IRQ_NEQ  0
`define FPX_IRQ_MUL  1
`define FPX_IRQ_RST  2'h0
// ------------------------------------------
// Exponent limits
// ------------------------------------------
`define FPX_BIAS     11'h07F
`define FPX_EXP_MAX  11'h0FF
`define FPX_DEN_MIN  11'h7E9
`define FPX_DEST_W   7
`endif

// ==== fpx_pkg.sv ====
// Types shared by the multiply-flags and not-equal unit
package fpx_pkg;
   typedef enum logic [1:0] {
      RM_NEAR = 2'b00,
      RM_ZERO = 2'b01,
      RM_POS  = 2'b10,
      RM_NEG  = 2'b11
   } rm_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  opcode;
      logic [31:0] first_operand;
      logic [31:0] second_operand;
      logic        has_guard;
      logic [31:0] guard;
      logic [6:0]  dest;
   } op_req_t;

   typedef struct packed {
      logic        valid;
      logic [6:0]  dest;
      logic [31:0] data;
   } wb_res_t;
endpackage

// ==== fp_mul_flags_neq.sv ====
// Multiply-flags and not-equal compare unit with status word
// Operation
// (RULE1) Multiply-flags returns would-be IEEE exceptions, latency 3
// (RULE2) Multiply-flags leaves status word flags alone
// (RULE3) Invalid 0x10, input flush 0x20, OUTPUT_FLUSHED_FLAG 0x40
// (RULE4) Overflow with inexact encodes as 0x0a
// (RULE5) Multiply-flags rounds per status word mode
// (RULE6) Denormal inputs become zero, set input flush
// (RULE7) Denormal product sets output flush bit
// (RULE8) Multiply-flags writes only when guard bit set
// (RULE9) Not-equal writes 1 if operands differ
// (RULE10) Not-equal flushes denormals, sets status input flush
// (RULE11) Not-equal exceptions set status word flags
// (RULE12) Status flags sticky, cleared only by write
// (RULE13) Flags update with the destination write
// (RULE14) Simultaneous updates OR into existing flags
// (RULE15) False guard blocks not-equal result and flags
// (RULE16) Missing guard means execute unconditionally
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "fpx_defs.svh"
module fp_mul_flags_neq (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire fpx_pkg::op_req_t  op_i,
   input  wire logic [6:0]        other_flags_i,
   output fpx_pkg::wb_res_t       mul_wb_o,
   output fpx_pkg::wb_res_t       neq_wb_o,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   output logic                   irq_o
);
   localparam int MUL_LAT = `FPX_MUL_LAT;

   // ------------------------------------------
   // Status word and issue decode
   // ------------------------------------------
   logic [6:0]      flags;
   fpx_pkg::rm_t    rm;
   logic [6:0]      neq_fl;
   logic [6:0]      next_flags;
   logic            run;
   logic            go_mul;
   logic            go_neq;
   logic            wr_psw;
   logic [31:0]     a;
   logic [31:0]     b;

   assign a = op_i.first_operand;
   assign b = op_i.second_operand;
   assign run = !op_i.has_guard || op_i.guard[0]; // see (RULE16)
   assign go_mul = op_i.valid && run
                   && op_i.opcode == `FPX_OP_MUL_FLAGS; // see (RULE8)
   assign go_neq = op_i.valid && run
                   && op_i.opcode == `FPX_OP_NEQ; // see (RULE15)

   function automatic logic is_den(input logic [31:0] x);
      return x[30:23] == 8'h00 && x[22:0] != 23'h000000;
   endfunction
   function automatic logic is_zero(input logic [31:0] x);
      return x[30:23] == 8'h00;
   endfunction
   function automatic logic is_nan(input logic [31:0] x);
      return x[30:23] == 8'hFF && x[22:0] != 23'h000000;
   endfunction
   function automatic logic is_inf(input logic [31:0] x);
      return x[30:23] == 8'hFF && x[22:0] == 23'h000000;
   endfunction

   // ------------------------------------------
   // Not-equal compare
   // ------------------------------------------
   logic neq_ne;
   logic any_nan;

   assign any_nan = is_nan(a) || is_nan(b);
   // Quiet NaN compares as not different, matching the unit's table
   assign neq_ne = !any_nan && !(is_zero(a) && is_zero(b))
                   && a != b; // see (RULE9) (RULE10)

   always_comb begin
      neq_fl = 7'h00;
      neq_fl[`FPX_FL_IFZ] = is_den(a) || is_den(b); // see (RULE10)
      neq_fl[`FPX_FL_INV] = (is_nan(a) && !a[22])
                            || (is_nan(b) && !b[22]); // see (RULE11)
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         neq_wb_o <= '0;
      end else if (ce_i) begin
         neq_wb_o.valid <= go_neq; // see (RULE13)
         neq_wb_o.dest <= op_i.dest;
         neq_wb_o.data <= {31'h00000000, neq_ne}; // see (RULE9)
      end
   end

   // ------------------------------------------
   // Multiply-flags stage 1: classify, multiply
   // ------------------------------------------
   logic               s1_v;
   logic [6:0]         s1_dest;
   fpx_pkg::rm_t       s1_rm;
   logic [6:0]         s1_fl;
   logic               s1_spec;
   logic               s1_sign;
   logic signed [10:0] s1_exp;
   logic [47:0]        s1_prod;
   logic [6:0]         in_fl;
   logic               zero_in;
   logic               inf_in;

   assign zero_in = is_zero(a) || is_zero(b); // see (RULE6)
   assign inf_in = is_inf(a) || is_inf(b);

   always_comb begin
      in_fl = 7'h00;
      in_fl[`FPX_FL_IFZ] = is_den(a) || is_den(b); // see (RULE6)
      in_fl[`FPX_FL_INV] = (zero_in && inf_in)
                           || (is_nan(a) && !a[22])
                           || (is_nan(b) && !b[22]); // see (RULE3)
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_v <= 1'b0;
         s1_dest <= 7'h00;
         s1_rm <= fpx_pkg::RM_NEAR;
         s1_fl <= 7'h00;
         s1_spec <= 1'b0;
         s1_sign <= 1'b0;
         s1_exp <= 11'sh000;
         s1_prod <= 48'h000000000000;
      end else if (ce_i) begin
         s1_v <= go_mul; // see (RULE1)
         s1_dest <= op_i.dest;
         s1_rm <= rm; // see (RULE5)
         s1_fl <= in_fl;
         s1_spec <= zero_in || inf_in || any_nan;
         s1_sign <= a[31] ^ b[31];
         s1_exp <= signed'({3'h0, a[30:23]} + {3'h0, b[30:23]}
                   - `FPX_BIAS);
         s1_prod <= {24'h000000, 1'b1, a[22:0]}
                    * {24'h000000, 1'b1, b[22:0]};
      end
   end

   // ------------------------------------------
   // Stage 2: normalise, round, classify range
   // ------------------------------------------
   logic [23:0]        mant;
   logic [23:0]        rest;
   logic [24:0]        mant_r;
   logic signed [10:0] e_n;
   logic signed [10:0] e_r;
   logic               up;
   logic               lost;
   logic [6:0]         mul_fl;
   logic               s2_v;
   logic [6:0]         s2_dest;
   logic [6:0]         s2_fl;

   always_comb begin
      if (s1_prod[47]) begin
         mant = s1_prod[47:24];
         rest = s1_prod[23:0];
         e_n = s1_exp + 11'sh001;
      end else begin
         mant = s1_prod[46:23];
         rest = {s1_prod[22:0], 1'b0};
         e_n = s1_exp;
      end
      lost = rest != 24'h000000;
      case (s1_rm) // see (RULE5)
         fpx_pkg::RM_NEAR: up = rest[23]
                               && (rest[22:0] != 23'h000000 || mant[0]);
         fpx_pkg::RM_ZERO: up = 1'b0;
         fpx_pkg::RM_POS:  up = !s1_sign && lost;
         fpx_pkg::RM_NEG:  up = s1_sign && lost;
         default:          up = 1'b0;
      endcase
      mant_r = {1'b0, mant} + {24'h000000, up};
      e_r = mant_r[24] ? e_n + 11'sh001 : e_n;
      mul_fl = s1_fl;
      if (!s1_spec) begin
         mul_fl[`FPX_FL_INX] = lost;
         if (e_r >= signed'(`FPX_EXP_MAX)) begin
            mul_fl[`FPX_FL_OVF] = 1'b1; // see (RULE4)
            mul_fl[`FPX_FL_INX] = 1'b1; // see (RULE4)
         end else if (e_n <= 11'sh000) begin
            // Tininess judged before rounding
            mul_fl[`FPX_FL_UNF] = 1'b1;
            mul_fl[`FPX_FL_INX] = 1'b1;
            mul_fl[`FPX_FL_OFZ] =
               e_n >= signed'(`FPX_DEN_MIN); // see (RULE7)
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s2_v <= 1'b0;
         s2_dest <= 7'h00;
         s2_fl <= 7'h00;
      end else if (ce_i) begin
         s2_v <= s1_v;
         s2_dest <= s1_dest;
         s2_fl <= mul_fl;
      end
   end

   // ------------------------------------------
   // Stage 3: result out, flags as integer
   // ------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mul_wb_o <= '0;
      end else if (ce_i) begin
         mul_wb_o.valid <= s2_v; // see (RULE1) (RULE8)
         mul_wb_o.dest <= s2_dest;
         mul_wb_o.data <= {25'h0000000, s2_fl}; // see (RULE2) (RULE3)
      end
   end

   // ------------------------------------------
   // Processor status word
   // ------------------------------------------
   logic       bus_hit;
   logic [6:0] wr_fl;

   assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_psw = bus_hit && wb_we_i && wb_adr_i == `FPX_ADR_PSW;
   assign wr_fl = wr_psw && wb_sel_i[0] ? wb_dat_i[6:0] : flags;

   // Set wins over an explicit clear in the same cycle
   always_comb begin
      next_flags = wr_fl | other_flags_i; // see (RULE12) (RULE14)
      if (go_neq) begin
         next_flags = next_flags | neq_fl; // see (RULE11) (RULE15)
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= `FPX_FL_RST;
      end else if (ce_i) begin
         flags <= next_flags; // see (RULE13)
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rm <= fpx_pkg::rm_t'(`FPX_RM_RST);
      end else if (ce_i && wr_psw && wb_sel_i[1]) begin
         rm <= fpx_pkg::rm_t'(wb_dat_i[`FPX_RM_LO +: 2]);
      end
   end

   // ------------------------------------------
   // Interrupt status, enable and clear
   // ------------------------------------------
   logic [1:0] ista;
   logic [1:0] ien;
   logic [1:0] iev;
   logic [1:0] iclr;

   assign iev[`FPX_IRQ_NEQ] = go_neq && neq_fl != 7'h00;
   assign iev[`FPX_IRQ_MUL] = s2_v && s2_fl != 7'h00;
   assign iclr = bus_hit && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == `FPX_ADR_ICLR ? wb_dat_i[1:0] : 2'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ista <= `FPX_IRQ_RST;
      end else if (ce_i) begin
         ista <= (ista & ~iclr) | iev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ien <= `FPX_IRQ_RST;
      end else if (ce_i && bus_hit && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == `FPX_ADR_IEN) begin
         ien <= wb_dat_i[1:0];
      end
   end

   assign irq_o = (ista & ien) != 2'h0;

   // ------------------------------------------
   // Wishbone slave, one wait state
   // ------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         wb_ack_o <= bus_hit;
         wb_dat_o <= 32'h00000000;
         if (wb_adr_i == `FPX_ADR_PSW) begin
            wb_dat_o <= {22'h000000, rm, 1'b0, flags};
         end else if (wb_adr_i == `FPX_ADR_ISTA) begin
            wb_dat_o <= {30'h00000000, ista};
         end else if (wb_adr_i == `FPX_ADR_IEN) begin
            wb_dat_o <= {30'h00000000, ien};
         end
      end
   end

   // ------------------------------------------
   // Assertions
   // ------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || !ce_i);

   sequence s_mul_go;
      go_mul;
   endsequence
   sequence s_neq_go;
      go_neq;
   endsequence
   sequence s_mul_den;
      go_mul && (is_den(a) || is_den(b));
   endsequence

   a_mul_latency: assert property ( // see (RULE1)
      s_mul_go |-> ##MUL_LAT mul_wb_o.valid
                   && mul_wb_o.dest == $past(op_i.dest, 3))
      else $error("multiply flags result not on time");

   a_mul_keeps_psw: assert property ( // see (RULE2)
      !go_neq && other_flags_i == 7'h00 && !wr_psw
      |=> flags == $past(flags))
      else $error("status flags moved without cause");

   a_flag_layout: assert property ( // see (RULE3)
      mul_wb_o.valid |-> mul_wb_o.data[31:7] == 25'h0000000
                         && !mul_wb_o.data[0])
      else $error("flag vector outside layout");

   a_ovf_inexact: assert property ( // see (RULE4)
      mul_wb_o.valid && mul_wb_o.data[`FPX_FL_OVF]
      |-> mul_wb_o.data[`FPX_FL_INX])
      else $error("overflow without inexact");

   a_rm_capture: assert property ( // see (RULE5)
      s_mul_go |=> s1_rm == $past(rm))
      else $error("rounding mode not taken at issue");

   a_mul_ifz: assert property ( // see (RULE6)
      s_mul_den |-> ##MUL_LAT mul_wb_o.data[`FPX_FL_IFZ])
      else $error("input flush missing");

   a_ofz_pair: assert property ( // see (RULE7)
      mul_wb_o.valid && mul_wb_o.data[`FPX_FL_OFZ]
      |-> mul_wb_o.data[`FPX_FL_UNF] && mul_wb_o.data[`FPX_FL_INX])
      else $error("output flush without underflow");

   a_mul_guard: assert property ( // see (RULE8)
      op_i.valid && op_i.opcode == `FPX_OP_MUL_FLAGS
      && op_i.has_guard && !op_i.guard[0]
      |-> ##MUL_LAT !mul_wb_o.valid)
      else $error("guarded multiply flags wrote");

   a_neq_result: assert property ( // see (RULE9)
      s_neq_go |=> neq_wb_o.valid
                   && neq_wb_o.data == {31'h00000000, $past(neq_ne)})
      else $error("not equal result wrong");

   a_neq_ifz: assert property ( // see (RULE10) (RULE13)
      s_neq_go ##0 (is_den(a) || is_den(b))
      |=> neq_wb_o.valid && flags[`FPX_FL_IFZ])
      else $error("compare input flush not in status");

   a_sticky_flags: assert property ( // see (RULE12)
      !wr_psw |=> (flags & $past(flags)) == $past(flags))
      else $error("sticky flag dropped");

   a_or_merge: assert property ( // see (RULE11) (RULE14)
      !wr_psw |=> flags == ($past(flags) | $past(other_flags_i)
                  | ($past(go_neq) ? $past(neq_fl) : 7'h00)))
      else $error("flags not OR of updates");

   a_neq_guard: assert property ( // see (RULE15) (RULE16)
      op_i.valid && op_i.opcode == `FPX_OP_NEQ
      |=> neq_wb_o.valid == $past(run))
      else $error("compare guard ignored");
endmodule // fp_mul_flags_neq

// ==== fpx_regfile_model.sv ====
// Register file model that takes the unit's destination writes
`timescale 1ns/1ns
module fpx_regfile_model (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire fpx_pkg::wb_res_t mul_wb_i,
   input  wire fpx_pkg::wb_res_t neq_wb_i
);
   // ------------------------------------------
   // Destination registers
   // ------------------------------------------
   // Reset to all ones so a stray write of 0 or 1 shows
   logic [31:0] regs [128];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 128; i++) begin
            regs[i] <= 32'hFFFF_FFFF;
         end
      end else begin
         if (mul_wb_i.valid) begin
            regs[mul_wb_i.dest] <= mul_wb_i.data;
         end
         if (neq_wb_i.valid) begin
            regs[neq_wb_i.dest] <= neq_wb_i.data;
         end
      end
   end
endmodule // fpx_regfile_model

// ==== fp_mul_flags_and_not_equal_tb_top.sv ====
// Self-checking bench for the multiply-flags and not-equal unit
`timescale 1ns/1ns
`include "fpx_defs.svh"
module fp_mul_flags_and_not_equal_tb_top;
   // ------------------------------------------
   // Signals
   // ------------------------------------------
   typedef struct {logic [7:0] op; logic [31:0] a; logic [31:0] b; logic [31:0] e;} row_t;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   fpx_pkg::op_req_t op_req = '0;
   logic [6:0]       other_flags = 7'h00;
   fpx_pkg::wb_res_t mul_wb_o, neq_wb_o, res;
   logic             cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic             ce = 1'b1;
   logic [7:0]       adr = 8'h00;
   logic [31:0]      wdat = 32'h0, rd, wb_dat_o;
   logic             wb_ack_o, irq_o;
   int               num_errors = 0, compares = 0, cycles = 0;
   localparam logic [7:0] M = `FPX_OP_MUL_FLAGS;
   localparam logic [7:0] N = `FPX_OP_NEQ;
   row_t rows [16] = '{
      '{M, 32'hC040_0000, 32'h3F80_0000, 32'h00}, '{M, 32'h4040_0000, 32'hC040_0000, 32'h00},
      '{M, 32'h3F00_0000, 32'h0080_0000, 32'h46}, '{M, 32'h7F80_0000, 32'h0000_0000, 32'h10},
      '{M, 32'h4040_0000, 32'h0040_0000, 32'h20}, '{M, 32'h00C0_0000, 32'h8080_0000, 32'h06},
      '{M, 32'h7F80_0000, 32'hFF80_0000, 32'h00}, '{M, 32'h7F7F_FFFF, 32'h7F7F_FFFF, 32'h0A},
      '{M, 32'h0080_0000, 32'h0080_0000, 32'h06}, '{N, 32'h4040_0000, 32'h0000_0000, 32'h01},
      '{N, 32'h4040_0000, 32'h4040_0000, 32'h00}, '{N, 32'h3F80_0000, 32'h0040_0000, 32'h01},
      '{N, 32'h3F80_0000, 32'h4040_0000, 32'h01}, '{N, 32'h4040_0000, 32'hFFFF_FFFF, 32'h00},
      '{N, 32'h7F80_0000, 32'hFF80_0000, 32'h01}, '{N, 32'h7F80_0000, 32'h7F80_0000, 32'h00}};

   always #20 clk_i = ~clk_i;

   fp_mul_flags_neq uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .op_i(op_req),
      .other_flags_i(other_flags), .mul_wb_o(mul_wb_o), .neq_wb_o(neq_wb_o),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
   fpx_regfile_model reg_model (.clk_i(clk_i), .rst_i(rst_i), .mul_wb_i(mul_wb_o),
      .neq_wb_i(neq_wb_o));

   // ------------------------------------------
   // Tasks
   // ------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Waits on ack with no cycle count assumed; the cycle ceiling ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic issue(input logic [7:0] opc, input logic [31:0] a, input logic [31:0] b,
                        input logic hg, input logic g, input logic [6:0] dst,
                        input logic [6:0] oth);
      @(posedge clk_i);
      op_req <= '{valid:1'b1, opcode:opc, first_operand:a, second_operand:b, has_guard:hg,
                  guard:{31'h0, g}, dest:dst};
      other_flags <= oth;
      @(posedge clk_i);
      op_req.valid <= 1'b0;
      other_flags <= 7'h00;
      if (opc == M) repeat (`FPX_MUL_LAT - 1) @(posedge clk_i);
      #1;
      res = (opc == M) ? mul_wb_o : neq_wb_o;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         summarize();
      end
   end

   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check({29'h0, mul_wb_o.valid, neq_wb_o.valid, irq_o}, 32'h0);
      wb(1'b0, `FPX_ADR_PSW, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, `FPX_ADR_ISTA, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 16; i++) begin
         if (i == 9) begin
            wb(1'b0, `FPX_ADR_PSW, 32'h0);
            check(rd, 32'h0);
         end
         issue(rows[i].op, rows[i].a, rows[i].b, 1'b0, 1'b0, 7'(i + 16), 7'h00);
         check({31'h0, res.valid}, 32'h1);
         check(res.data, rows[i].e);
         check({25'h0, res.dest}, 32'(i + 16));
      end
      // Flush flag from the denormal compare stays through later compares
      wb(1'b0, `FPX_ADR_PSW, 32'h0);
      check(rd, 32'h20);
      wb(1'b0, `FPX_ADR_ISTA, 32'h0);
      check(rd, 32'h3);
      check({31'h0, irq_o}, 32'h0);
      wb(1'b1, `FPX_ADR_IEN, 32'h1);
      check({31'h0, irq_o}, 32'h1);
      wb(1'b1, `FPX_ADR_ICLR, 32'h1);
      wb(1'b0, `FPX_ADR_ISTA, 32'h0);
      check(rd, 32'h2);
      check({31'h0, irq_o}, 32'h0);
      wb(1'b1, `FPX_ADR_ICLR, 32'h2);
      wb(1'b0, `FPX_ADR_ISTA, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, `FPX_ADR_PSW, 32'h100);
      wb(1'b0, `FPX_ADR_PSW, 32'h0);
      check(rd, 32'h100);
      issue(M, 32'h7F7F_FFFF, 32'h7F7F_FFFF, 1'b0, 1'b0, 7'h02, 7'h00);
      check(res.data, 32'h0A);
      // Product just below the top: round to zero keeps it finite
      issue(M, 32'h7F4A_6691, 32'h3FA1_E58F, 1'b0, 1'b0, 7'h03, 7'h00);
      check(res.data, 32'h02);
      wb(1'b1, `FPX_ADR_PSW, 32'h0);
      issue(M, 32'h7F4A_6691, 32'h3FA1_E58F, 1'b0, 1'b0, 7'h03, 7'h00);
      check(res.data, 32'h0A);
      issue(N, 32'h3F80_0000, 32'h0040_0000, 1'b1, 1'b0, 7'h05, 7'h00);
      check({31'h0, res.valid}, 32'h0);
      issue(M, 32'h3F00_0000, 32'h0080_0000, 1'b1, 1'b0, 7'h09, 7'h00);
      check({31'h0, res.valid}, 32'h0);
      check(reg_model.regs[5], 32'hFFFF_FFFF);
      check(reg_model.regs[9], 32'hFFFF_FFFF);
      wb(1'b0, `FPX_ADR_PSW, 32'h0);
      check(rd, 32'h0);
      issue(M, 32'h3F00_0000, 32'h0080_0000, 1'b1, 1'b1, 7'h09, 7'h00);
      check(res.data, 32'h46);
      issue(8'h1C, 32'h3F80_0000, 32'h0040_0000, 1'b0, 1'b0, 7'h06, 7'h00);
      check({31'h0, res.valid}, 32'h0);
      // Another unit's underflow lands on the same edge as the compare's flush
      issue(N, 32'h3F80_0000, 32'h0040_0000, 1'b1, 1'b1, 7'h05, 7'h04);
      check(res.data, 32'h1);
      check(reg_model.regs[9], 32'h46);
      wb(1'b0, `FPX_ADR_PSW, 32'h0);
      check(rd, 32'h24);
      wb(1'b1, 8'h20, 32'hFFFF_FFFF);
      wb(1'b0, 8'h20, 32'h0);
      check(rd, 32'h0);
      // Enable low freezes flags; set input drops a cycle before enable returns
      @(posedge clk_i);
      ce <= 1'b0;
      other_flags <= 7'h08;
      repeat (2) @(posedge clk_i);
      other_flags <= 7'h00;
      @(posedge clk_i);
      ce <= 1'b1;
      wb(1'b0, `FPX_ADR_PSW, 32'h0);
      check(rd, 32'h24);
      check({31'h0, irq_o}, 32'h1);
      // Reset in mid-run clears flags, enables and results
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check({29'h0, mul_wb_o.valid, neq_wb_o.valid, irq_o}, 32'h0);
      wb(1'b0, `FPX_ADR_PSW, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, `FPX_ADR_IEN, 32'h0);
      check(rd, 32'h0);
      summarize();
   end
endmodule // fp_mul_flags_and_not_equal_tb_top
